// file: core/rpg_map.svh
// Offsets, field positions, sizes, masks and codes of the page guard
`ifndef RPG_MAP_SVH
`define RPG_MAP_SVH
`define RPG_A_ID 8'h00
`define RPG_A_CTRL 8'h04
`define RPG_A_LIMIT 8'h08
`define RPG_A_ARG 8'h0C
`define RPG_A_CMD 8'h10
`define RPG_A_STAT 8'h14
`define RPG_A_SCODE 8'h18
`define RPG_A_SI1L 8'h1C
`define RPG_A_SI1H 8'h20
`define RPG_A_SI2 8'h24
`define RPG_A_SEVT 8'h28
`define RPG_A_SNRIP 8'h2C
`define RPG_A_VINTR 8'h30
`define RPG_LEVELS 4'h4
`define RPG_PAGES 16
`define RPG_ID_LVL_LSB 12
`define RPG_F_LIMIT 1
`define RPG_F_REFLECT 2
`define RPG_ALIGN_MASK 12'hE00
`define RPG_PERM_FULL 4'hF
`define RPG_CODE_NOT_VALID 32'h0000_0404
`define RPG_CODE_NPF 32'h0000_0400
`define RPG_CODE_VC_EXIT 32'h0000_0041
`define RPG_EI_ENC 34
`define RPG_EI_SIZEM 35
`define RPG_EI_LVL 36
`define RPG_EVT_VALID 31
`endif

// file: core/rpg_pkg.sv
// Types of the page guard
package rpg_pkg;
   typedef enum logic [1:0] {
      RPG_OP_UPDATE,
      RPG_OP_VALIDATE,
      RPG_OP_ADJUST,
      RPG_OP_NONE
   } rpg_op_t;
   typedef struct packed {
      logic [11:0] gpa;
      logic [7:0] tag;
      logic asg;
      logic sz;
      logic lock;
      logic val;
      logic [3:0][3:0] perm;
   } rpg_entry_t;
   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic cpl3;
      logic [11:0] gpa_pg;
      logic [7:0] spa_pg;
      logic [1:0] npt_size;
      logic gpte_c;
      logic in_delivery;
      logic [31:0] gva;
      logic [31:0] nrip;
   } rpg_acc_t;
   typedef struct packed {
      logic done;
      logic grant;
      logic eff_c;
      logic pf_rsv;
      logic vc;
      logic [31:0] vc_code;
      logic [31:0] cr2;
      logic exit;
      logic [31:0] exit_code;
      logic [63:0] exit_info_one;
      logic [31:0] exit_info_two;
   } rpg_res_t;
endpackage : rpg_pkg

// file: core/rpg_guard.sv
// Page owner table, its operations and the guest access check
// Overview of operation
// - Entry update takes only address, owner, size, lock and tag from the argument.
// - Owner flag and tag (and lock) decide hypervisor, guest or processor.
// - Private access faults when recorded address or size mismatch mapping.
// - Unlocked pages may return to hypervisor; locked entries refuse updates.
// - Zeroed table is hypervisor-owned; pages beyond table stay hypervisor.
// - Private access to an unvalidated page raises the comm exception.
// - Newly assigned pages start not validated.
// - Page validate sets or clears the validated flag.
// - Unassign, reassign or remap by update clears validated.
// - Validate 4KB over large mapping faults; 2MB over 4KB errors.
// - Levels count from 0; number of levels in id bits 15:12.
// - One mask per level; accesses check the current level's mask.
// - Mask bits read, write, user exec, supervisor exec; rest zero.
// - Level permission faults set a dedicated exit info bit.
// - Assignment gives level 0 full rights and others none.
// - Permission adjust touches only numerically higher levels.
// - Permission adjust fails granting rights the caller lacks.
// - With private limit on, data below limit is encrypted, above not.
// - With private limit on, guest table encryption bit faults reserved.
// - Exception exit enable turns comm exceptions into exits.
// - Reflected exit uses its code and saves original event details.
// - Reflection during delivery sets event valid and maybe busy.
// - Saved exit fields are filled on every automatic exit.
// - Exit info bit 36 flags level permission failures.
// - Validation failure reports code 0x404 and the faulting address.
`timescale 1ns/100ps
`include "rpg_map.svh"
module rpg_guard (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire rpg_pkg::rpg_acc_t acc,
   output rpg_pkg::rpg_res_t res
);
   rpg_pkg::rpg_entry_t tbl_r [`RPG_PAGES];
   logic [7:0] feat_r;
   logic alt_r;
   logic [1:0] lvl_r;
   logic [7:0] tag_r;
   logic [11:0] limit_r;
   logic [31:0] arg_r;
   logic [2:0] stat_r;
   logic [2:0] stat_nxt;
   logic [31:0] scode_r;
   logic [63:0] si1_r;
   logic [31:0] si2_r;
   logic [31:0] sevt_r;
   logic [31:0] snrip_r;
   logic busy_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   rpg_pkg::rpg_res_t res_r;
   rpg_pkg::rpg_res_t res_nxt;

   // Pages past the table read as a zero entry: hypervisor-owned
   function automatic logic covered(input logic [7:0] pg);
      covered = pg < 8'(`RPG_PAGES);
   endfunction : covered

   // Operation decode
   wire cmd_wr = wr && addr == `RPG_A_CMD;
   wire rpg_pkg::rpg_op_t op = rpg_pkg::rpg_op_t'(wdata[1:0]);
   wire [7:0] idx = wdata[11:4];
   wire [1:0] op_npt = wdata[13:12];
   wire op_cov = covered(idx);
   wire rpg_pkg::rpg_entry_t e_op = op_cov ? tbl_r[idx[3:0]] : '0;
   wire [11:0] na_gpa = arg_r[11:0];
   wire [7:0] na_tag = arg_r[19:12];
   wire na_asg = arg_r[20];
   wire na_sz = arg_r[21];
   wire na_lock = arg_r[22];
   wire [1:0] tl = arg_r[25:24];
   wire [3:0] msk = arg_r[31:28];

   // Locked entries belong to the security processor only
   wire upd_ok = op_cov && !e_op.lock;
   wire upd_chg = na_asg != e_op.asg || na_tag != e_op.tag ||
      na_gpa != e_op.gpa || na_sz != e_op.sz;
   wire own_op = op_cov && e_op.asg && e_op.tag == tag_r;
   wire v_npf = own_op && !na_sz && op_npt != 2'b00;
   wire v_err = own_op && na_sz && op_npt == 2'b00;
   wire v_ok = own_op && !v_npf && !v_err;
   wire a_ok = own_op && tl > lvl_r &&
      (msk & ~e_op.perm[lvl_r]) == 4'h0;
   wire upd_fire = cmd_wr && op == rpg_pkg::RPG_OP_UPDATE;
   wire val_fire = cmd_wr && op == rpg_pkg::RPG_OP_VALIDATE;
   wire adj_fire = cmd_wr && op == rpg_pkg::RPG_OP_ADJUST;

   rpg_pkg::rpg_entry_t e_new;
   always_comb begin
      e_new = e_op;
      stat_nxt = stat_r;
      unique case (op)
         rpg_pkg::RPG_OP_UPDATE: begin
            e_new.gpa = na_gpa;
            e_new.tag = na_tag;
            e_new.asg = na_asg;
            e_new.sz = na_sz;
            e_new.lock = na_lock;
            if (upd_chg) begin
               e_new.val = 1'b0;
            end
            if (upd_chg && na_asg) begin
               e_new.perm = {12'h000, `RPG_PERM_FULL};
            end
            stat_nxt = {2'b00, !upd_ok};
         end
         rpg_pkg::RPG_OP_VALIDATE: begin
            e_new.val = arg_r[23];
            stat_nxt = {v_npf, v_err, !v_ok};
         end
         rpg_pkg::RPG_OP_ADJUST: begin
            e_new.perm[tl] = msk;
            stat_nxt = {2'b00, !a_ok};
         end
         rpg_pkg::RPG_OP_NONE: begin
            stat_nxt = stat_r;
         end
      endcase
   end
   wire tbl_we = (upd_fire && upd_ok) || (val_fire && v_ok) ||
      (adj_fire && a_ok);

   // Access check
   wire a_cov = covered(acc.spa_pg);
   wire rpg_pkg::rpg_entry_t ea = a_cov ? tbl_r[acc.spa_pg[3:0]] : '0;
   wire is_data = !acc.kind[1];
   wire lim_on = feat_r[`RPG_F_LIMIT];
   wire below = acc.gpa_pg < (limit_r & `RPG_ALIGN_MASK);
   // Fetches and table walks are always private
   wire eff_c = !is_data || (lim_on ? below : acc.gpte_c);
   wire pf_rsv = lim_on && acc.gpte_c;
   wire own_a = a_cov && ea.asg && ea.tag == tag_r;
   wire map_ok = ea.gpa == acc.gpa_pg &&
      ea.sz == (acc.npt_size != 2'b00);
   wire npf_rmp = eff_c ? !(own_a && map_ok && !ea.lock) : ea.asg;
   wire vc_hit = eff_c && !npf_rmp && !ea.val;
   wire [3:0] pm = ea.perm[lvl_r];
   wire need = acc.kind == 2'd1 ? pm[1] :
      acc.kind == 2'd2 ? (acc.cpl3 ? pm[2] : pm[3]) : pm[0];
   wire lvl_f = eff_c && !npf_rmp && !vc_hit && !need;
   wire a_npf = acc.valid && !pf_rsv && (npf_rmp || lvl_f);
   wire a_vc = acc.valid && !pf_rsv && vc_hit;
   wire reflect = a_vc && feat_r[`RPG_F_REFLECT];
   wire [63:0] i1 = (64'(eff_c) << `RPG_EI_ENC) |
      (64'(lvl_f) << `RPG_EI_LVL);
   wire [63:0] i1_op = 64'h0000_0000_0000_0001 << `RPG_EI_SIZEM;
   wire op_exit = val_fire && v_npf;
   wire any_exit = a_npf || reflect || op_exit;

   always_comb begin
      res_nxt = '0;
      res_nxt.done = acc.valid;
      res_nxt.grant = acc.valid && !pf_rsv && !a_npf && !a_vc;
      res_nxt.eff_c = eff_c;
      res_nxt.pf_rsv = acc.valid && pf_rsv;
      res_nxt.vc = a_vc && !reflect;
      res_nxt.vc_code = `RPG_CODE_NOT_VALID;
      res_nxt.cr2 = acc.gva;
      res_nxt.exit = any_exit;
      res_nxt.exit_code = reflect ? `RPG_CODE_VC_EXIT : `RPG_CODE_NPF;
      res_nxt.exit_info_one = reflect ? 64'h0 : (a_npf ? i1 : i1_op);
      res_nxt.exit_info_two = {20'h00000, acc.gpa_pg};
   end

   // Register read
   always_comb begin
      unique case (addr)
         `RPG_A_ID: rdata_nxt = 32'(`RPG_LEVELS) << `RPG_ID_LVL_LSB;
         `RPG_A_CTRL: rdata_nxt = {12'h000, tag_r, lvl_r, 1'b0, alt_r, feat_r};
         `RPG_A_LIMIT: rdata_nxt = {20'h00000, limit_r};
         `RPG_A_ARG: rdata_nxt = arg_r;
         `RPG_A_STAT: rdata_nxt = {29'h0, stat_r};
         `RPG_A_SCODE: rdata_nxt = scode_r;
         `RPG_A_SI1L: rdata_nxt = si1_r[31:0];
         `RPG_A_SI1H: rdata_nxt = si1_r[63:32];
         `RPG_A_SI2: rdata_nxt = si2_r;
         `RPG_A_SEVT: rdata_nxt = sevt_r;
         `RPG_A_SNRIP: rdata_nxt = snrip_r;
         `RPG_A_VINTR: rdata_nxt = {31'h0, busy_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `RPG_PAGES; i++) begin
            tbl_r[i] <= '0;
         end
      end else if (tbl_we) begin
         tbl_r[idx[3:0]] <= e_new;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         feat_r <= 8'h00;
         alt_r <= 1'b0;
         lvl_r <= 2'b00;
         tag_r <= 8'h00;
         limit_r <= 12'h000;
         arg_r <= 32'h0000_0000;
         stat_r <= 3'b000;
      end else begin
         if (wr && addr == `RPG_A_CTRL) begin
            feat_r <= wdata[7:0];
            alt_r <= wdata[8];
            lvl_r <= wdata[11:10];
            tag_r <= wdata[19:12];
         end
         if (wr && addr == `RPG_A_LIMIT) begin
            limit_r <= wdata[11:0];
         end
         if (wr && addr == `RPG_A_ARG) begin
            arg_r <= wdata;
         end
         if (cmd_wr) begin
            stat_r <= stat_nxt;
         end
      end
   end

   // Busy set beats a software clear in the same cycle
   wire busy_set = reflect && acc.in_delivery && alt_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scode_r <= 32'h0000_0000;
         si1_r <= 64'h0;
         si2_r <= 32'h0000_0000;
         sevt_r <= 32'h0000_0000;
         snrip_r <= 32'h0000_0000;
         busy_r <= 1'b0;
      end else begin
         if (any_exit) begin
            scode_r <= reflect ? `RPG_CODE_NOT_VALID
               : res_nxt.exit_code;
            si1_r <= reflect ? 64'h0 : res_nxt.exit_info_one;
            si2_r <= reflect ? acc.gva : res_nxt.exit_info_two;
            sevt_r <= reflect ? 32'(acc.in_delivery) << `RPG_EVT_VALID
               : 32'h0000_0000;
            snrip_r <= acc.nrip;
         end
         if (busy_set) begin
            busy_r <= 1'b1;
         end else if (wr && addr == `RPG_A_VINTR) begin
            busy_r <= wdata[0];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         res_r <= '0;
         rdata_r <= 32'h0000_0000;
      end else begin
         res_r <= res_nxt;
         rdata_r <= rd ? rdata_nxt : 32'h0000_0000;
      end
   end
   assign res = res_r;
   assign rdata = rdata_r;

   // Index of the previous cycle's command, only for the table assertions
   logic [3:0] op_idx_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         op_idx_q <= 4'h0;
      end else begin
         op_idx_q <= idx[3:0];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_upd_lock_refuse: assert property (upd_fire && e_op.lock |=>
      stat_r[0] && tbl_r[op_idx_q] == $past(e_op))
      else $error("locked entry changed by update");
   a_upd_clear_val: assert property (upd_fire && upd_ok && upd_chg |=>
      !tbl_r[op_idx_q].val)
      else $error("validated flag survived remap");
   a_assign_perm: assert property (upd_fire && upd_ok && upd_chg &&
      na_asg |=> tbl_r[op_idx_q].perm == 16'h000F)
      else $error("assignment rights wrong");
   a_adjust_own_lvl: assert property (adj_fire && tl <= lvl_r |=>
      stat_r[0])
      else $error("adjust of own level accepted");
   a_vc_report: assert property (a_vc && !feat_r[2] |=> res.vc &&
      res.vc_code == 32'h0000_0404 && res.cr2 == $past(acc.gva))
      else $error("comm exception report wrong");
   a_reflect_exit: assert property (a_vc && feat_r[2] |=> res.exit &&
      !res.vc && scode_r == 32'h0000_0404)
      else $error("reflection missing");
   a_lvl_bit: assert property (a_npf |=>
      res.exit_info_one[36] == $past(lvl_f) && res.exit)
      else $error("level fault bit wrong");
   a_walk_enc: assert property (acc.valid && acc.kind[1] |=>
      res.eff_c)
      else $error("fetch or walk not private");
   a_rsv_fault: assert property (acc.valid && lim_on &&
      acc.gpte_c |=> res.pf_rsv && !res.grant)
      else $error("reserved bit fault missing");
   a_id_levels: assert property (rd && addr == 8'h00 |=>
      rdata[15:12] == 4'h4)
      else $error("level count wrong");
   a_busy_set: assert property (busy_set |=> busy_r)
      else $error("busy bit not set by reflection");
   a_beyond_shared: assert property (acc.valid && !a_cov &&
      !acc.kind[1] && !lim_on && !acc.gpte_c |=> res.grant)
      else $error("page beyond table not hypervisor-owned");
   a_val_size_exit: assert property (val_fire && v_npf |=>
      res.exit && res.exit_info_one[35])
      else $error("validate size fault exit missing");
   a_saved_npf: assert property (a_npf && !reflect |=>
      scode_r == 32'h0000_0400)
      else $error("saved exit code wrong");

   c_grant: cover property (acc.valid ##1 res.grant);
   c_reflect: cover property (reflect && acc.in_delivery ##1 busy_r);
   c_adjust_ok: cover property (adj_fire && a_ok);
   c_val_npf: cover property (op_exit ##1 res.exit);
endmodule : rpg_guard

// file: verification/rpg_guest_model.sv
// Guest software model issuing memory accesses to the page guard
`timescale 1ns/100ps
module rpg_guest_model (
   input wire logic clock,
   output rpg_pkg::rpg_acc_t acc,
   input wire rpg_pkg::rpg_res_t res
);
   initial acc = '0;
   // One access; the answer is taken in the cycle where it stands
   task automatic touch(input logic [1:0] k, input logic u,
      input logic [11:0] g, input logic [7:0] s, input logic [1:0] n,
      input logic c, input logic d, output rpg_pkg::rpg_res_t r);
      rpg_pkg::rpg_acc_t a;
      a = {1'b1, k, u, g, s, n, c, d, 8'hC0, 12'h000, g, 20'h0_0401, g};
      @(posedge clock);
      acc <= a;
      @(posedge clock);
      // Idle fields scrambled so stale values cannot pass for answers
      acc <= {1'b0, ~a[$bits(a)-2:0]};
      #1 r = res;
   endtask : touch
endmodule : rpg_guest_model

// file: verification/testbench.sv
// Self-checking bench of the page guard
`timescale 1ns/100ps
`include "rpg_map.svh"
module testbench;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] v;
   rpg_pkg::rpg_acc_t acc;
   rpg_pkg::rpg_res_t res;
   rpg_pkg::rpg_res_t r;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   localparam logic [33:0] NPF = {2'b11, `RPG_CODE_NPF};
   localparam logic [33:0] VC = {2'b10, `RPG_CODE_NOT_VALID};
   localparam logic [3:0] OK = 4'hC;
   rpg_guard i_rpg_guard (.clock(clock), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .acc(acc), .res(res));
   rpg_guest_model i_rpg_guest_model (.clock(clock), .acc(acc), .res(res));
   always #5 clock = ~clock;
   // Run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rreg
   function automatic logic [31:0] arg(input logic [11:0] g,
      input logic [7:0] t, input logic [3:0] f, input logic [1:0] l,
      input logic [3:0] m);
      return {m, 2'b00, l, f, t, g};
   endfunction : arg
   // Entry operation; status left in v
   task automatic op(input logic [1:0] o, input logic [7:0] pg,
      input logic [1:0] n, input logic [31:0] a);
      wreg(`RPG_A_ARG, a);
      wreg(`RPG_A_CMD, {18'h0, n, pg, 2'b00, o});
      rreg(`RPG_A_STAT);
   endtask : op
   task automatic lvl(input logic [1:0] l, input logic [8:0] f);
      wreg(`RPG_A_CTRL, {12'h000, 8'h05, l, 1'b0, f});
   endtask : lvl
   task automatic go(input logic [1:0] k, input logic [11:0] g,
      input logic [7:0] s, input logic [1:0] n, input logic c);
      i_rpg_guest_model.touch(k, 1'b0, g, s, n, c, 1'b0, r);
   endtask : go
   task automatic s_reset();
      wreg(`RPG_A_ID, 32'h0000_0000);
      rreg(`RPG_A_ID);
      check(v[15:12], `RPG_LEVELS);
      rreg(`RPG_A_SCODE);
      check(v, 32'h0000_0000);
   endtask : s_reset
   task automatic s_owner();
      lvl(2'd0, 9'h000);
      go(2'd0, 12'h010, 8'd1, 2'd0, 1'b0);
      check({r.done, r.grant, r.exit, r.vc}, OK);
      go(2'd1, 12'h010, 8'd40, 2'd0, 1'b0);
      check({r.done, r.grant, r.exit, r.vc}, OK);
      go(2'd0, 12'h010, 8'd40, 2'd0, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
      go(2'd0, 12'h010, 8'd1, 2'd0, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
   endtask : s_owner
   task automatic s_assign();
      // Validate value and mask in the argument must be ignored
      op(2'd0, 8'd1, 2'd0, arg(12'h010, 8'h05, 4'b1001, 2'd1, 4'hF));
      check(v[0], 1'b0);
      go(2'd0, 12'h010, 8'd1, 2'd0, 1'b1);
      check({r.vc, r.exit, r.vc_code}, VC);
      check(r.cr2, 32'hC000_0010);
      go(2'd0, 12'h011, 8'd1, 2'd0, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
      check(r.exit_info_one[36], 1'b0);
      go(2'd0, 12'h010, 8'd1, 2'd1, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
      go(2'd1, 12'h010, 8'd1, 2'd0, 1'b0);
      check({r.done, r.exit, r.exit_code}, NPF);
   endtask : s_assign
   task automatic s_validate();
      op(2'd1, 8'd1, 2'd0, arg(12'h010, 8'h00, 4'b1010, 2'd0, 4'h0));
      check(v[2:0], 3'b011);
      op(2'd1, 8'd1, 2'd1, arg(12'h010, 8'h00, 4'b1000, 2'd0, 4'h0));
      check(v[2:0], 3'b101);
      rreg(`RPG_A_SI1H);
      check(v, 32'h0000_0008);
      for (int i = 0; i < 3; i++) begin
         op(2'd1, 8'd1, 2'd0, arg(12'h010, 8'h00, {i != 1, 3'b000}, 2'd0,
            4'h0));
         check(v[2:0], 3'b000);
         go(2'd0, 12'h010, 8'd1, 2'd0, 1'b1);
         check({r.vc, r.grant}, (i != 1) ? 2'b01 : 2'b10);
      end
   endtask : s_validate
   task automatic s_levels();
      logic [1:0] k;
      lvl(2'd1, 9'h000);
      go(2'd0, 12'h010, 8'd1, 2'd0, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
      check(r.exit_info_one[36], 1'b1);
      for (int b = 0; b < 4; b++) begin
         lvl(2'd0, 9'h000);
         op(2'd2, 8'd1, 2'd0, arg(12'h010, 8'h00, 4'h0, 2'd1, 4'h1 << b));
         check(v[0], 1'b0);
         lvl(2'd1, 9'h000);
         for (int a = 0; a < 4; a++) begin
            k = (a < 2) ? a[1:0] : 2'd2;
            i_rpg_guest_model.touch(k, a == 2, 12'h010, 8'd1, 2'd0, 1'b1,
               1'b0, r);
            check(r.grant, a == b);
            check(r.exit_info_one[36], a != b);
         end
      end
      op(2'd2, 8'd1, 2'd0, arg(12'h010, 8'h00, 4'h0, 2'd1, 4'h8));
      check(v[0], 1'b1);
      op(2'd2, 8'd1, 2'd0, arg(12'h010, 8'h00, 4'h0, 2'd0, 4'h8));
      check(v[0], 1'b1);
      op(2'd2, 8'd1, 2'd0, arg(12'h010, 8'h00, 4'h0, 2'd2, 4'h1));
      check(v[0], 1'b1);
      op(2'd2, 8'd1, 2'd0, arg(12'h010, 8'h00, 4'h0, 2'd2, 4'h8));
      check(v[0], 1'b0);
      lvl(2'd2, 9'h000);
      go(2'd2, 12'h010, 8'd1, 2'd0, 1'b1);
      check({r.done, r.grant, r.exit, r.vc}, OK);
   endtask : s_levels
   task automatic s_remap();
      lvl(2'd0, 9'h000);
      op(2'd0, 8'd1, 2'd0, arg(12'h012, 8'h05, 4'b0001, 2'd0, 4'h0));
      go(2'd0, 12'h012, 8'd1, 2'd0, 1'b1);
      check({r.vc, r.exit, r.vc_code}, VC);
      op(2'd1, 8'd1, 2'd0, arg(12'h012, 8'h00, 4'b1000, 2'd0, 4'h0));
      lvl(2'd2, 9'h000);
      go(2'd2, 12'h012, 8'd1, 2'd0, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
   endtask : s_remap
   task automatic s_lock();
      lvl(2'd0, 9'h000);
      op(2'd0, 8'd2, 2'd0, arg(12'h020, 8'h00, 4'b0101, 2'd0, 4'h0));
      check(v[0], 1'b0);
      op(2'd0, 8'd2, 2'd0, 32'h0000_0000);
      check(v[0], 1'b1);
      // No-op command must leave the status alone
      op(2'd3, 8'd2, 2'd0, 32'h0000_0000);
      check(v[0], 1'b1);
      go(2'd0, 12'h020, 8'd2, 2'd0, 1'b0);
      check({r.done, r.exit, r.exit_code}, NPF);
      op(2'd0, 8'd1, 2'd0, 32'h0000_0000);
      check(v[0], 1'b0);
      go(2'd0, 12'h012, 8'd1, 2'd0, 1'b0);
      check({r.done, r.grant, r.exit, r.vc}, OK);
   endtask : s_lock
   task automatic s_limit();
      lvl(2'd0, 9'h002);
      // Low nine bits of the limit must be ignored
      wreg(`RPG_A_LIMIT, 32'h0000_03FF);
      go(2'd0, 12'h1FF, 8'd3, 2'd0, 1'b0);
      check(r.eff_c, 1'b1);
      go(2'd1, 12'h200, 8'd3, 2'd0, 1'b0);
      check({r.grant, r.eff_c}, 2'b10);
      go(2'd3, 12'h200, 8'd3, 2'd0, 1'b0);
      check(r.eff_c, 1'b1);
      go(2'd0, 12'h200, 8'd3, 2'd0, 1'b1);
      check({r.done, r.pf_rsv, r.grant}, 3'b110);
   endtask : s_limit
   task automatic s_reflect();
      lvl(2'd0, 9'h104);
      op(2'd0, 8'd3, 2'd0, arg(12'h030, 8'h05, 4'b0001, 2'd0, 4'h0));
      i_rpg_guest_model.touch(2'd0, 1'b0, 12'h030, 8'd3, 2'd0, 1'b1, 1'b1, r);
      check({r.vc, r.exit, r.exit_code}, {2'b01, `RPG_CODE_VC_EXIT});
      rreg(`RPG_A_SCODE);
      check(v, `RPG_CODE_NOT_VALID);
      rreg(`RPG_A_SI2);
      check(v, 32'hC000_0030);
      rreg(`RPG_A_SNRIP);
      check(v, 32'h0040_1030);
      rreg(`RPG_A_SEVT);
      check(v[31], 1'b1);
      rreg(`RPG_A_VINTR);
      check(v[0], 1'b1);
      go(2'd0, 12'h031, 8'd3, 2'd0, 1'b1);
      check({r.done, r.exit, r.exit_code}, NPF);
      rreg(`RPG_A_SCODE);
      check(v, `RPG_CODE_NPF);
      rreg(`RPG_A_SI1H);
      check(v, 32'h0000_0004);
      rreg(`RPG_A_SI2);
      check(v, 32'h0000_0031);
   endtask : s_reflect
   initial begin
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      s_reset();
      s_owner();
      s_assign();
      s_validate();
      s_levels();
      s_remap();
      s_lock();
      s_limit();
      s_reflect();
      summarize();
   end
endmodule : testbench
